// File: rtl/rsl_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none
module rsl_strap_latch
  import rsl_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  // Strap pins, already resolved to logic or level codes
  input  wire logic [PORT_COUNT-1:0] port_dplus_off_strap,
  input  wire logic [PORT_COUNT-1:0] port_dminus_off_strap,
  input  wire logic [CODE_W-1:0]     fixed_port_count_strap,
  input  wire logic [CODE_W-1:0]     charge_port_count_strap,
  input  wire logic [MODE_W-1:0]     device_mode_strap,
  // Decoded defaults and capture status
  output var  logic [PORT_COUNT-1:0] port_usb2_on,
  output var  logic [PORT_COUNT-1:0] port_ss_on,
  output var  logic [PORT_COUNT-1:0] port_fixed,
  output var  logic [PORT_COUNT-1:0] port_dcp_on,
  output var  logic [PORT_COUNT-1:0] port_cdp_on,
  output var  logic [MODE_W-1:0]     device_mode,
  output var  logic                  strap_window,
  output var  logic                  config_valid,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr
);

  // Synchronised strap levels
  logic [STRAP_W-1:0]    strap_sync;
  logic [PORT_COUNT-1:0] dplus_sync;
  logic [PORT_COUNT-1:0] dminus_sync;
  logic [CODE_W-1:0]     fixed_sync;
  logic [CODE_W-1:0]     charge_sync;
  logic [MODE_W-1:0]     mode_sync;

  // Captured straps
  logic [PORT_COUNT-1:0] dplus_reg;
  logic [PORT_COUNT-1:0] dminus_reg;
  logic [CODE_W-1:0]     fixed_reg;
  logic [CODE_W-1:0]     charge_reg;
  logic [MODE_W-1:0]     mode_reg;

  rsl_state_t            state_reg;
  rsl_state_t            state_next;
  logic [3:0]            settle_reg;
  logic [PORT_COUNT-1:0] sw_off_reg;
  logic [PORT_COUNT-1:0] disabled;
  logic [31:0]           rd_next;
  logic                  addr_ok;
  logic                  setup;
  logic                  done;
  logic                  wr_ctrl;
  logic                  core_reset_n;

  rsl_dec_if fixed_if ();
  rsl_dec_if charge_if ();

  // Reset pin releases at any time; retimed so no flop on core_reset_n leaves reset mid-edge (u_sync stays on reset_n)
  rsl_sync #(
    .W (1)
  ) u_reset_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .d       (1'b1),
    .q       (core_reset_n)
  );

  // Pins come from the board, so they cross into the clock domain first
  rsl_sync #(
    .W (STRAP_W)
  ) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .d       ({port_dplus_off_strap, port_dminus_off_strap, fixed_port_count_strap,
                charge_port_count_strap, device_mode_strap}),
    .q       (strap_sync)
  );

  assign {dplus_sync, dminus_sync, fixed_sync, charge_sync, mode_sync} = strap_sync;

  rsl_level_dec u_fixed_dec (
    .bus (fixed_if)
  );

  rsl_level_dec u_charge_dec (
    .bus (charge_if)
  );

  assign fixed_if.code  = fixed_reg;
  assign charge_if.code = charge_reg;

  // Capture sequence

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SETTLE: begin
        // Wait for the synchroniser to fill and the pins to settle
        if (settle_reg == SETTLE_LAST) begin
          state_next = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        state_next = ST_HELD;
      end
      ST_HELD: begin
        state_next = ST_HELD;
      end
    endcase
  end

  // Every reset, power-on or external, restarts the sequence
  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      state_reg <= ST_SETTLE;  // [R01]
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      settle_reg <= '0;
    end else if (state_reg == ST_SETTLE && settle_reg != SETTLE_LAST) begin
      settle_reg <= settle_reg + 4'h1;
    end
  end

  // Straps are taken exactly once per reset and then left alone
  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      dplus_reg  <= '0;
      dminus_reg <= '0;
      fixed_reg  <= LVL_200K_DOWN;
      charge_reg <= LVL_200K_DOWN;
      mode_reg   <= '0;
    end else if (state_reg == ST_CAPTURE) begin  // [R01] [R13]
      dplus_reg  <= dplus_sync;   // [R03]
      dminus_reg <= dminus_sync;  // [R04]
      fixed_reg  <= fixed_sync;
      charge_reg <= charge_sync;
      mode_reg   <= mode_sync;    // [R10]
    end
  end

  // Pins belong to the strap function until the capture is done
  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      strap_window <= 1'b1;
    end else begin
      strap_window <= (state_next != ST_HELD);  // [R02]
    end
  end

  // Valid rises with the first decoded outputs, never ahead of them
  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      config_valid <= 1'b0;
    end else begin
      config_valid <= (state_reg == ST_HELD);  // [R01]
    end
  end

  // Decoded defaults

  assign disabled = dplus_reg & dminus_reg;  // [R05]

  // Outputs stay off until the capture has produced real values
  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      port_usb2_on <= '0;
    end else if (state_reg == ST_HELD) begin
      port_usb2_on <= ~disabled & ~sw_off_reg;  // [R05]
    end else begin
      port_usb2_on <= '0;
    end
  end

  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      port_ss_on <= '0;
    end else if (state_reg == ST_HELD) begin
      port_ss_on <= ~disabled & ~sw_off_reg;  // [R06]
    end else begin
      port_ss_on <= '0;
    end
  end

  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      port_fixed <= '0;
    end else if (state_reg == ST_HELD) begin
      port_fixed <= fixed_if.mask;  // [R07]
    end else begin
      port_fixed <= '0;
    end
  end

  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      port_dcp_on <= '0;
    end else if (state_reg == ST_HELD) begin
      port_dcp_on <= charge_if.mask;  // [R08] [R09]
    end else begin
      port_dcp_on <= '0;
    end
  end

  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      port_cdp_on <= '0;
    end else if (state_reg == ST_HELD) begin
      port_cdp_on <= charge_if.mask;  // [R09]
    end else begin
      port_cdp_on <= '0;
    end
  end

  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      device_mode <= '0;
    end else if (state_reg == ST_HELD) begin
      device_mode <= mode_reg;  // [R10]
    end else begin
      device_mode <= '0;
    end
  end

  // APB slave, no wait states: the answer is prepared in the setup cycle

  assign setup   = psel && !penable;
  assign done    = psel && penable && pready;
  assign wr_ctrl = done && pwrite && (paddr == OFS_CTRL);

  always_comb begin
    rd_next = RDATA_RESET;
    addr_ok = 1'b1;
    unique case (paddr)
      OFS_STATUS: begin
        rd_next[FLD_VALID]  = config_valid;
        rd_next[FLD_WINDOW] = strap_window;
      end
      OFS_PORTS: begin
        rd_next[FLD_DPLUS +: PORT_COUNT]  = dplus_reg;
        rd_next[FLD_DMINUS +: PORT_COUNT] = dminus_reg;
      end
      OFS_CODES: begin
        rd_next[FLD_FIXED +: CODE_W]  = fixed_reg;
        rd_next[FLD_CHARGE +: CODE_W] = charge_reg;
        rd_next[FLD_MODE +: MODE_W]   = mode_reg;
      end
      OFS_MASKS: begin
        rd_next[FLD_USB2_ON +: PORT_COUNT] = port_usb2_on;
        rd_next[FLD_FIX_MSK +: PORT_COUNT] = port_fixed;
        rd_next[FLD_CHG_MSK +: PORT_COUNT] = port_dcp_on;
      end
      OFS_CTRL: begin
        rd_next[PORT_COUNT-1:0] = sw_off_reg;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      pready <= 1'b0;
    end else if (done) begin
      pready <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
    end
  end

  // Read data and error are frozen in the setup cycle and held to completion
  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      prdata  <= RDATA_RESET;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? RDATA_RESET : rd_next;
      pslverr <= !addr_ok;
    end else if (done) begin
      prdata  <= RDATA_RESET;
      pslverr <= 1'b0;
    end
  end

  // Software port-off mask; it masks port_usb2_on and port_ss_on but never the captured straps
  always_ff @(posedge clock or negedge core_reset_n) begin
    if (!core_reset_n) begin
      sw_off_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      sw_off_reg <= pwdata[PORT_COUNT-1:0];
    end
  end

endmodule // rsl_strap_latch
`default_nettype wire

// File: rtl/rsl_pkg.sv
// Behaviour
// (R01) Sample all straps at power-on and again when external reset is released.
// (R02) Pins act as straps only around reset; captured once, then freed.
// (R03) Captured D+ strap per port: 0 means D+ enabled, 1 disabled.
// (R04) Captured D- strap per port: 0 means D- enabled, 1 disabled.
// (R05) Port disabled only when both its D+ and D- straps are high.
// (R06) Disabling a port's USB 2.0 path also disables its SuperSpeed path.
// (R07) Fixed-port code picks none, port 1, 1-2, 1-3, 1-4 or 1-6 non-removable.
// (R08) Charge-port code picks none, port 1, 1-2, 1-3, 1-4 or 1-6 charging.
// (R09) Each charge-selected port enables both dedicated and downstream charging modes.
// (R10) Three captured mode straps choose the operating mode.
// (R11) Board must hold straps at their levels before the capture point.
// (R12) External reset input is active low, driven by the system.
// (R13) Captured values stay fixed until the next reset.
package rsl_pkg;

  localparam int PORT_COUNT = 6;
  localparam int CODE_W     = 3;
  localparam int MODE_W     = 3;
  localparam int STRAP_W    = 2 * PORT_COUNT + 3 * CODE_W;

  // Settle time after reset release before the straps are trusted
  localparam int CLOCK_MHZ           = 40;
  localparam int STRAP_SETTLE_NS     = 100;
  localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [3:0] SETTLE_LAST = 4'(STRAP_SETTLE_CYCLES - 1);

  // Six-level resistor code from the analog detector
  localparam logic [2:0] LVL_200K_DOWN = 3'h0;
  localparam logic [2:0] LVL_200K_UP   = 3'h1;
  localparam logic [2:0] LVL_10K_DOWN  = 3'h2;
  localparam logic [2:0] LVL_10K_UP    = 3'h3;
  localparam logic [2:0] LVL_10R_DOWN  = 3'h4;
  localparam logic [2:0] LVL_10R_UP    = 3'h5;

  localparam logic [5:0] MASK_NONE = 6'h00;
  localparam logic [5:0] MASK_P1   = 6'h01;
  localparam logic [5:0] MASK_P12  = 6'h03;
  localparam logic [5:0] MASK_P13  = 6'h07;
  localparam logic [5:0] MASK_P14  = 6'h0F;
  localparam logic [5:0] MASK_P16  = 6'h3F;

  // APB register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_PORTS  = 8'h04;
  localparam logic [7:0] OFS_CODES  = 8'h08;
  localparam logic [7:0] OFS_MASKS  = 8'h0C;
  localparam logic [7:0] OFS_CTRL   = 8'h10;

  // Field positions
  localparam int FLD_DPLUS   = 0;
  localparam int FLD_DMINUS  = 8;
  localparam int FLD_FIXED   = 0;
  localparam int FLD_CHARGE  = 8;
  localparam int FLD_MODE    = 16;
  localparam int FLD_USB2_ON = 0;
  localparam int FLD_FIX_MSK = 8;
  localparam int FLD_CHG_MSK = 16;
  localparam int FLD_VALID   = 0;
  localparam int FLD_WINDOW  = 1;

  localparam logic [5:0]  CTRL_RESET  = 6'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_CAPTURE,
    ST_HELD
  } rsl_state_t;

endpackage

// File: rtl/rsl_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rsl_dec_if;
  logic [2:0] code;
  logic [5:0] mask;
  modport dec  (input code, output mask);
  modport user (output code, input mask);
endinterface // rsl_dec_if
`default_nettype wire

// File: rtl/rsl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rsl_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // rsl_sync
`default_nettype wire

// File: rtl/rsl_level_dec.sv
`timescale 1ns/1ps
`default_nettype none
module rsl_level_dec
  import rsl_pkg::*;
(
  rsl_dec_if.dec bus
);

  always_comb begin
    unique case (bus.code)
      LVL_200K_DOWN: bus.mask = MASK_NONE;  // [R07] [R08]
      LVL_200K_UP:   bus.mask = MASK_P1;
      LVL_10K_DOWN:  bus.mask = MASK_P12;
      LVL_10K_UP:    bus.mask = MASK_P13;
      LVL_10R_DOWN:  bus.mask = MASK_P14;
      LVL_10R_UP:    bus.mask = MASK_P16;
      // Reserved codes fall back to the safest setting
      default:       bus.mask = MASK_NONE;
    endcase
  end

endmodule // rsl_level_dec
`default_nettype wire

// File: testbench/rsl_strap_latch_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rsl_strap_latch_assertions
  import rsl_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire logic [PORT_COUNT-1:0] port_dplus_off_strap,
  input wire logic [PORT_COUNT-1:0] port_dminus_off_strap,
  input wire logic [MODE_W-1:0]     device_mode_strap,
  input wire logic [PORT_COUNT-1:0] port_usb2_on,
  input wire logic [PORT_COUNT-1:0] port_ss_on,
  input wire logic [PORT_COUNT-1:0] port_fixed,
  input wire logic [PORT_COUNT-1:0] port_dcp_on,
  input wire logic [PORT_COUNT-1:0] port_cdp_on,
  input wire logic [MODE_W-1:0]     device_mode,
  input wire logic                  strap_window,
  input wire logic                  config_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_ss_follows_usb2: assert property (port_ss_on == port_usb2_on)
    else $error("superspeed enable differs from usb2 enable");
  a_cdp_pairs_dcp: assert property (port_cdp_on == port_dcp_on)
    else $error("downstream charging differs from dedicated charging");
  a_window_closed: assert property (config_valid |-> !strap_window)
    else $error("strap window open after capture");
  a_capture_soon: assert property ($rose(reset_n) |-> strap_window ##[1:8] config_valid)
    else $error("no capture after reset release");
  a_idle_zero: assert property (!config_valid |-> port_fixed == 6'h00 && port_dcp_on == 6'h00)
    else $error("decoded outputs set before capture");
  a_held_steady: assert property (config_valid && $past(config_valid, 4) |->
    $stable(port_fixed) && $stable(port_dcp_on) && $stable(device_mode))
    else $error("captured value moved between resets");
  a_mode_taken: assert property ($rose(config_valid) ##2 1 |-> device_mode == $past(device_mode_strap, 6))
    else $error("mode not captured from mode straps");
  a_dplus_low_on: assert property ($rose(config_valid) ##2 1 |-> &(port_usb2_on | $past(port_dplus_off_strap, 6)))
    else $error("port off with its plus strap low");
  a_dminus_low_on: assert property ($rose(config_valid) ##2 1 |-> &(port_usb2_on | $past(port_dminus_off_strap, 6)))
    else $error("port off with its minus strap low");
  a_both_high_off: assert property ($rose(config_valid) ##2 1 |->
    (port_usb2_on & $past(port_dplus_off_strap, 6) & $past(port_dminus_off_strap, 6)) == 6'h00)
    else $error("port on with both straps high");
  c_capture: cover property ($rose(config_valid));
  c_port_off: cover property (config_valid && port_usb2_on != 6'h3F);
  c_all_fixed: cover property (port_fixed == 6'h3F);
endmodule // rsl_strap_latch_assertions
`default_nettype wire

// File: testbench/rsl_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsl_board_model
  import rsl_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_req,
  input  wire logic [STRAP_W-1:0] cfg,
  output var  logic               reset_n,
  output var  logic [STRAP_W-1:0] pins
);
  logic [3:0]         hold_cnt;
  logic [STRAP_W-1:0] noise;
  // Combinational so the design sits in reset from time zero
  assign reset_n = !rst_req;
  always_ff @(posedge clock) begin
    if (rst_req) begin
      hold_cnt <= 4'h0;
    end else if (hold_cnt != 4'hF) begin
      hold_cnt <= hold_cnt + 4'h1;
    end
  end
  // Shared pins take their other function later: busy traffic
  always_ff @(posedge clock) begin
    noise <= rst_req ? ~cfg : ~noise;
  end
  assign pins = (rst_req || hold_cnt < 4'hC) ? cfg : noise;
endmodule // rsl_board_model
`default_nettype wire

// File: testbench/rsl_strap_latch_test.sv
`timescale 1ns/1ps
`default_nettype none
module rsl_strap_latch_test
  import rsl_pkg::*;
;
  logic clock = 1'b0, rst_req = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reset_n, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [STRAP_W-1:0] cfg = '0, pins;
  logic [5:0] usb2, ss, fixd, dcp, cdp, dp, dm;
  logic [2:0] mode;
  logic win, valid, err;
  int failures = 0, checks_done = 0;
  always #12.5 clock = ~clock;
  rsl_board_model board (.clock(clock), .rst_req(rst_req), .cfg(cfg), .reset_n(reset_n), .pins(pins));
  rsl_strap_latch uut (.clock(clock), .reset_n(reset_n), .port_dplus_off_strap(pins[5:0]),
    .port_dminus_off_strap(pins[11:6]), .fixed_port_count_strap(pins[14:12]),
    .charge_port_count_strap(pins[17:15]), .device_mode_strap(pins[20:18]), .port_usb2_on(usb2),
    .port_ss_on(ss), .port_fixed(fixd), .port_dcp_on(dcp), .port_cdp_on(cdp), .device_mode(mode),
    .strap_window(win), .config_valid(valid), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin failures++; print_verdict(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle edge, so a following call never re-raises psel in the same step
    @(posedge clock);
  endtask
  // Straps held through capture, then pins go busy before checking
  task boot(input logic [STRAP_W-1:0] c);
    int n;
    cfg <= c; rst_req <= 1'b1;
    repeat (5) @(posedge clock);
    chk(32'({win, valid, mode, usb2, fixd, dcp}), 32'h0040_0000);
    rst_req <= 1'b0;
    for (n = 0; n < 30 && valid !== 1'b1; n++) @(posedge clock);
    if (n == 30) begin failures++; print_verdict(); end
    repeat (16) @(posedge clock);
  endtask
  function automatic logic [5:0] msk(input logic [2:0] c);
    return c == 3'h5 ? 6'h3F : (c > 3'h4 ? 6'h00 : 6'((7'h01 << c) - 7'h01));
  endfunction
  initial begin
    for (int i = 0; i < 8; i++) begin
      dp = 6'(8'h5A >> i); dm = 6'(8'hC6 >> i);
      boot({3'(i), 3'(7 - i), 3'(i), dm, dp});
      chk(32'(fixd), 32'(msk(3'(i))));
      chk(32'(dcp), 32'(msk(3'(7 - i))));
      chk(32'(cdp), 32'(msk(3'(7 - i))));
      chk(32'(mode), 32'(i));
      chk(32'({ss, usb2}), 32'({2{~(dp & dm)}}));
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, {18'h0, dm, 2'h0, dp});
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'({3'(i), 5'h0, 3'(7 - i), 5'h0, 3'(i)}));
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'({msk(3'(7 - i)), 2'h0, msk(3'(i)), 2'h0, ~(dp & dm)}));
      $display("test strap set %0d done", i);
    end
    apb(1'b1, 8'h10, 32'h3F);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h3F);
    repeat (2) @(posedge clock);
    chk(32'({ss, usb2}), 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, {18'h0, dm, 2'h0, dp});
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    $display("test register access done");
    print_verdict();
  end
endmodule // rsl_strap_latch_test
bind rsl_strap_latch rsl_strap_latch_assertions chk_i (.clock, .reset_n, .port_dplus_off_strap,
  .port_dminus_off_strap, .device_mode_strap, .port_usb2_on, .port_ss_on, .port_fixed, .port_dcp_on,
  .port_cdp_on, .device_mode, .strap_window, .config_valid);
`default_nettype wire
